// [common/crre_pkg.sv]
package crre_pkg;
   localparam logic [15:0] PID_MEAS_MAX      = 16'h2710;
   localparam logic [15:0] PID_DEV_MAX       = 16'h2710;
   localparam logic [15:0] DISABLE_CODE      = 16'hffff;
   localparam int          CHAIN_SLOTS       = 5;
   localparam logic [2:0]  TRQ_SRC_A         = 3'h3;
   localparam logic [2:0]  TRQ_SRC_B         = 3'h5;
   localparam logic [1:0]  TRQ_LIM_METHOD    = 2'h2;
   localparam logic [15:0] TRQ_MAX_A_DEF     = 16'h0fa0;
   localparam logic [15:0] TRQ_MAX_B_DEF     = 16'h2710;
   localparam int          EXEC_CYCLES       = 2;
   localparam logic [15:0] RESET_WORD        = 16'h0000;

   typedef struct packed {
      logic [15:0] code;
      logic [15:0] data;
   } crre_slot_t;

   typedef struct packed {
      logic [7:0]  ext;
      logic [7:0]  instr;
      logic [15:0] data;
      logic [2:0]  index;
   } crre_cmd_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_RUN  = 4'b0010,
      ST_NEXT = 4'b0100,
      ST_DONE = 4'b1000
   } crre_state_t;
endpackage

// [src/crre_top.sv]
`timescale 1ns/1ps
module crre_top #(
   parameter logic [15:0] TRQ_MAX_A = crre_pkg::TRQ_MAX_A_DEF,
   parameter logic [15:0] TRQ_MAX_B = crre_pkg::TRQ_MAX_B_DEF
) (
   input  wire logic                  clk_in,
   input  wire logic                  rst_in,
   input  wire logic [15:0]           pid_measured_word_in,
   input  wire logic [15:0]           pid_deviation_word_in,
   input  wire logic [15:0]           torque_word_in,
   input  wire logic                  ram_write_request_in,
   input  wire logic                  nonvolatile_write_request_in,
   input  wire logic [2:0]            torque_source_selection_in,
   input  wire logic [1:0]            torque_limit_input_method_in,
   input  wire logic                  torque_control_mode_in,
   input  wire logic                  vector_mode_in,
   input  wire logic                  frequency_sign_selection_in,
   input  wire logic [15:0]           set_frequency_in,
   input  wire logic                  start_reverse_in,
   input  wire logic                  instruction_execute_request_in,
   input  wire crre_pkg::crre_slot_t  base_slot_in,
   input  wire crre_pkg::crre_slot_t  [crre_pkg::CHAIN_SLOTS-1:0] chain_slot_in,
   input  wire logic                  cmd_ack_in,
   output logic [15:0]                pid_measured_out,
   output logic [15:0]                pid_deviation_out,
   output logic [15:0]                torque_param_ram_copy_out,
   output logic [15:0]                torque_param_second_copy_out,
   output logic                       torque_is_command_out,
   output logic                       torque_is_limit_out,
   output logic [15:0]                freq_magnitude_out,
   output logic                       run_reverse_out,
   output crre_pkg::crre_cmd_t        cmd_out,
   output logic                       cmd_valid_out,
   output logic                       instruction_done_flag_out
);
   import crre_pkg::*;

   typedef struct packed {
      logic [15:0] pid_meas;
      logic [15:0] pid_dev;
      logic [15:0] trq_ram;
      logic [15:0] trq_sec;
      logic        trq_cmd;
      logic        trq_lim;
      logic [15:0] freq_mag;
      logic        rev;
      crre_state_t st;
      logic [2:0]  slot;
      crre_cmd_t   cmd;
      logic        cmd_valid;
      logic        done;
      logic        req_d;
   } crre_st_t;

   crre_st_t s_r, s_nxt;

   // 16'h8000 maps to itself and so fails every range check
   function automatic logic [15:0] abs16(input logic [15:0] v);
      abs16 = v[15] ? 16'((~v) + 16'h0001) : v;
   endfunction

   function automatic crre_cmd_t make_cmd(input crre_slot_t sl, input logic [2:0] idx);
      make_cmd.ext   = sl.code[15:8];
      make_cmd.instr = sl.code[7:0];
      make_cmd.data  = sl.data;
      make_cmd.index = idx;
   endfunction

   logic        src_ok;
   logic        trq_mode_cmd;
   logic        trq_mode_lim;
   logic [15:0] trq_range;
   logic        trq_commit;
   logic        req_rise;

   assign src_ok       = (torque_source_selection_in == TRQ_SRC_A) || (torque_source_selection_in == TRQ_SRC_B);
   assign trq_mode_cmd = src_ok && torque_control_mode_in && vector_mode_in;
   // limit mode means not torque control; vector mode not required
   assign trq_mode_lim = src_ok && !torque_control_mode_in
                         && (torque_limit_input_method_in == TRQ_LIM_METHOD);
   assign trq_range    = (torque_source_selection_in == TRQ_SRC_A) ? TRQ_MAX_A : TRQ_MAX_B;
   assign trq_commit   = ram_write_request_in || nonvolatile_write_request_in;
   assign req_rise     = instruction_execute_request_in && !s_r.req_d;

   always_comb begin
      s_nxt = s_r;
      // edge detect on the request, so a held request never restarts the chain
      s_nxt.req_d = instruction_execute_request_in;
      // words arrive pre-scaled by one hundred from the master
      if (pid_measured_word_in <= PID_MEAS_MAX) begin
         s_nxt.pid_meas = pid_measured_word_in;
      end
      if (abs16(pid_deviation_word_in) <= PID_DEV_MAX) begin
         s_nxt.pid_dev = pid_deviation_word_in;
      end
      s_nxt.trq_cmd = trq_mode_cmd;
      s_nxt.trq_lim = trq_mode_lim;
      if (trq_commit && (trq_mode_cmd || trq_mode_lim)
          && (abs16(torque_word_in) <= trq_range)) begin
         s_nxt.trq_ram = torque_word_in;
         s_nxt.trq_sec = torque_word_in;
      end
      if (frequency_sign_selection_in) begin
         s_nxt.freq_mag = abs16(set_frequency_in);
         s_nxt.rev      = start_reverse_in ^ set_frequency_in[15];
      end else begin
         s_nxt.freq_mag = set_frequency_in;
         s_nxt.rev      = start_reverse_in;
      end
      case (s_r.st)
         ST_IDLE: begin
            if (req_rise) begin
               s_nxt.cmd       = make_cmd(base_slot_in, 3'h0);
               s_nxt.cmd_valid = 1'b1;
               s_nxt.slot      = 3'h0;
               s_nxt.st        = ST_RUN;
            end
         end
         ST_RUN: begin
            if (cmd_ack_in) begin
               s_nxt.cmd_valid = 1'b0;
               s_nxt.st        = ST_NEXT;
            end
         end
         ST_NEXT: begin
            // one slot per cycle; disabled ones are passed over
            if (s_r.slot == 3'(CHAIN_SLOTS)) begin
               s_nxt.done = 1'b1;
               s_nxt.st   = ST_DONE;
            end else begin
               s_nxt.slot = 3'(s_r.slot + 3'h1);
               if (chain_slot_in[s_r.slot].code != DISABLE_CODE) begin
                  s_nxt.cmd       = make_cmd(chain_slot_in[s_r.slot], 3'(s_r.slot + 3'h1));
                  s_nxt.cmd_valid = 1'b1;
                  s_nxt.st        = ST_RUN;
               end
            end
         end
         ST_DONE: begin
            if (!instruction_execute_request_in) begin
               s_nxt.done = 1'b0;
               s_nxt.st   = ST_IDLE;
            end
         end
         default: s_nxt.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_r <= '{pid_meas: RESET_WORD, pid_dev: RESET_WORD, trq_ram: RESET_WORD, trq_sec: RESET_WORD,
                  trq_cmd: 1'b0, trq_lim: 1'b0, freq_mag: RESET_WORD, rev: 1'b0, st: ST_IDLE,
                  slot: 3'h0, cmd: '0, cmd_valid: 1'b0, done: 1'b0, req_d: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign pid_measured_out             = s_r.pid_meas;
   assign pid_deviation_out            = s_r.pid_dev;
   assign torque_param_ram_copy_out    = s_r.trq_ram;
   assign torque_param_second_copy_out = s_r.trq_sec;
   assign torque_is_command_out        = s_r.trq_cmd;
   assign torque_is_limit_out          = s_r.trq_lim;
   assign freq_magnitude_out           = s_r.freq_mag;
   assign run_reverse_out              = s_r.rev;
   assign cmd_out                      = s_r.cmd;
   assign cmd_valid_out                = s_r.cmd_valid;
   assign instruction_done_flag_out    = s_r.done;

   // pid words: out-of-range words leave the held value alone
   a_pid_range: assert property (@(posedge clk_in) disable iff (rst_in)
      pid_measured_word_in > PID_MEAS_MAX |=> $stable(pid_measured_out))
      else $error("pid measured changed on out-of-range word");
   a_pid_take: assert property (@(posedge clk_in) disable iff (rst_in)
      pid_measured_word_in <= PID_MEAS_MAX |=> pid_measured_out == $past(pid_measured_word_in))
      else $error("pid measured not taken");
   a_meas_bound: assert property (@(posedge clk_in) disable iff (rst_in)
      pid_measured_out <= PID_MEAS_MAX)
      else $error("pid measured above full scale");
   a_dev_range: assert property (@(posedge clk_in) disable iff (rst_in)
      abs16(pid_deviation_word_in) > PID_DEV_MAX |=> $stable(pid_deviation_out))
      else $error("pid deviation changed on out-of-range word");
   a_dev_take: assert property (@(posedge clk_in) disable iff (rst_in)
      abs16(pid_deviation_word_in) <= PID_DEV_MAX |=> pid_deviation_out == $past(pid_deviation_word_in))
      else $error("pid deviation not taken");
   a_dev_bound: assert property (@(posedge clk_in) disable iff (rst_in)
      abs16(pid_deviation_out) <= PID_DEV_MAX)
      else $error("pid deviation beyond full scale");

   // torque word: both copies move together, only on a request
   a_trq_copies: assert property (@(posedge clk_in) disable iff (rst_in)
      torque_param_ram_copy_out == torque_param_second_copy_out)
      else $error("torque copies differ");
   a_trq_nocommit: assert property (@(posedge clk_in) disable iff (rst_in)
      !trq_commit |=> $stable(torque_param_ram_copy_out))
      else $error("torque changed without write request");
   a_trq_commit: assert property (@(posedge clk_in) disable iff (rst_in)
      trq_commit && (trq_mode_cmd || trq_mode_lim) && abs16(torque_word_in) <= trq_range
      |=> torque_param_second_copy_out == $past(torque_word_in))
      else $error("torque word not committed");
   a_trq_range: assert property (@(posedge clk_in) disable iff (rst_in)
      abs16(torque_word_in) > trq_range |=> $stable(torque_param_second_copy_out))
      else $error("out-of-range torque word taken");
   a_trq_nosrc: assert property (@(posedge clk_in) disable iff (rst_in)
      !src_ok |=> $stable(torque_param_ram_copy_out) && !torque_is_command_out && !torque_is_limit_out)
      else $error("torque word used with wrong source");
   a_trq_cmd_set: assert property (@(posedge clk_in) disable iff (rst_in)
      src_ok && torque_control_mode_in && vector_mode_in |=> torque_is_command_out)
      else $error("torque command mode not entered");
   a_trq_cmd_vec: assert property (@(posedge clk_in) disable iff (rst_in)
      !vector_mode_in |=> !torque_is_command_out)
      else $error("torque command outside vector mode");
   a_trq_lim_mode: assert property (@(posedge clk_in) disable iff (rst_in)
      torque_limit_input_method_in != TRQ_LIM_METHOD |=> !torque_is_limit_out)
      else $error("torque limit without method 2");
   a_trq_lim_set: assert property (@(posedge clk_in) disable iff (rst_in)
      src_ok && !torque_control_mode_in && torque_limit_input_method_in == TRQ_LIM_METHOD |=> torque_is_limit_out)
      else $error("torque limit mode not entered");
   a_trq_exclusive: assert property (@(posedge clk_in) disable iff (rst_in)
      !(torque_is_command_out && torque_is_limit_out))
      else $error("torque word both command and limit");

   // set frequency: sign select decides signed or raw
   a_freq_rev: assert property (@(posedge clk_in) disable iff (rst_in)
      frequency_sign_selection_in && set_frequency_in[15] |=> run_reverse_out == !$past(start_reverse_in))
      else $error("negative frequency did not reverse");
   a_freq_fwd: assert property (@(posedge clk_in) disable iff (rst_in)
      frequency_sign_selection_in && !set_frequency_in[15] |=> run_reverse_out == $past(start_reverse_in))
      else $error("positive frequency changed direction");
   a_freq_signed: assert property (@(posedge clk_in) disable iff (rst_in)
      frequency_sign_selection_in |=> freq_magnitude_out == abs16($past(set_frequency_in)))
      else $error("signed frequency magnitude wrong");
   a_freq_raw: assert property (@(posedge clk_in) disable iff (rst_in)
      !frequency_sign_selection_in |=> freq_magnitude_out == $past(set_frequency_in))
      else $error("unsigned frequency altered");

   // executor chain
   a_base_first: assert property (@(posedge clk_in) disable iff (rst_in)
      s_r.st == ST_IDLE && req_rise |=> cmd_valid_out && cmd_out.index == 3'h0)
      else $error("base slot not issued first");
   a_base_data: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(cmd_valid_out) && cmd_out.index == 3'h0
      |-> {cmd_out.ext, cmd_out.instr, cmd_out.data} == $past(base_slot_in))
      else $error("base code or data not carried");
   a_base_ext: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(cmd_valid_out) && cmd_out.index == 3'h0 |-> cmd_out.ext == $past(base_slot_in.code[15:8]))
      else $error("extended setting not from upper byte");
   a_chain_order: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(cmd_valid_out) && cmd_out.index != 3'h0 |-> cmd_out.index > $past(cmd_out.index))
      else $error("chained slot out of order");
   a_slot_bound: assert property (@(posedge clk_in) disable iff (rst_in)
      s_r.slot <= 3'(CHAIN_SLOTS))
      else $error("slot counter past last slot");
   a_state_onehot: assert property (@(posedge clk_in) disable iff (rst_in)
      $onehot(s_r.st))
      else $error("executor state not one-hot");
   a_valid_hold: assert property (@(posedge clk_in) disable iff (rst_in)
      cmd_valid_out && !cmd_ack_in |=> cmd_valid_out && $stable(cmd_out))
      else $error("command changed before acknowledge");
   a_valid_drop: assert property (@(posedge clk_in) disable iff (rst_in)
      cmd_valid_out && cmd_ack_in |=> !cmd_valid_out)
      else $error("command valid held after acknowledge");
   a_skip_off: assert property (@(posedge clk_in) disable iff (rst_in)
      cmd_valid_out && cmd_out.index != 3'h0 |-> {cmd_out.ext, cmd_out.instr} != DISABLE_CODE)
      else $error("disabled slot issued");
   a_done_late: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(instruction_done_flag_out) |-> $past(s_r.slot) == 3'(CHAIN_SLOTS))
      else $error("done before last slot");
   a_done_idle: assert property (@(posedge clk_in) disable iff (rst_in)
      instruction_done_flag_out |-> !cmd_valid_out)
      else $error("done while a command is pending");
   a_done_hold: assert property (@(posedge clk_in) disable iff (rst_in)
      instruction_done_flag_out && instruction_execute_request_in |=> instruction_done_flag_out)
      else $error("done dropped while request held");
   a_done_clear: assert property (@(posedge clk_in) disable iff (rst_in)
      instruction_done_flag_out && !instruction_execute_request_in |=> !instruction_done_flag_out)
      else $error("done kept after request dropped");
   a_done_fell: assert property (@(posedge clk_in) disable iff (rst_in)
      $fell(instruction_done_flag_out) |-> !$past(instruction_execute_request_in))
      else $error("done cleared while request high");
   a_no_restart: assert property (@(posedge clk_in) disable iff (rst_in)
      instruction_done_flag_out |=> !$rose(cmd_valid_out))
      else $error("chain restarted without fresh request");
endmodule

// [sim/crre_exec_model.sv]
`timescale 1ns/1ps
module crre_exec_model #(
   parameter int ACK_DELAY = 2
) (
   input  wire logic                clk_in,
   input  wire logic                rst_in,
   input  wire crre_pkg::crre_cmd_t cmd_in,
   input  wire logic                cmd_valid_in,
   output logic                     cmd_ack_out
);
   import crre_pkg::*;
   crre_cmd_t log_q[$];
   int        wait_r;
   // one-cycle ack so a held valid is never acknowledged twice
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cmd_ack_out <= 1'b0;
         wait_r <= 0;
      end else if (cmd_ack_out) begin
         cmd_ack_out <= 1'b0;
         wait_r <= 0;
      end else if (cmd_valid_in === 1'b1) begin
         if (wait_r == ACK_DELAY) begin
            cmd_ack_out <= 1'b1;
            log_q.push_back(cmd_in);
         end else begin
            wait_r <= wait_r + 1;
         end
      end
   end
endmodule

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
   import crre_pkg::*;
   logic                         clk_in, rst_in, ram_req, nv_req, trq_ctl, vec, sgn, rev_in, exec_req, ack;
   logic [15:0]                  meas, dev, trq, freq, meas_o, dev_o, ram_o, sec_o, mag_o;
   logic [2:0]                   src;
   logic [1:0]                   meth;
   logic                         is_cmd, is_lim, rev_o, valid, done;
   crre_slot_t                   base;
   crre_slot_t [CHAIN_SLOTS-1:0] chain;
   crre_cmd_t                    cmd;
   int                           miscompares = 0;
   int                           checks = 0;

   crre_top dut (.clk_in(clk_in), .rst_in(rst_in), .pid_measured_word_in(meas), .pid_deviation_word_in(dev),
      .torque_word_in(trq), .ram_write_request_in(ram_req), .nonvolatile_write_request_in(nv_req),
      .torque_source_selection_in(src), .torque_limit_input_method_in(meth), .torque_control_mode_in(trq_ctl),
      .vector_mode_in(vec), .frequency_sign_selection_in(sgn), .set_frequency_in(freq),
      .start_reverse_in(rev_in), .instruction_execute_request_in(exec_req), .base_slot_in(base),
      .chain_slot_in(chain), .cmd_ack_in(ack), .pid_measured_out(meas_o), .pid_deviation_out(dev_o),
      .torque_param_ram_copy_out(ram_o), .torque_param_second_copy_out(sec_o), .torque_is_command_out(is_cmd),
      .torque_is_limit_out(is_lim), .freq_magnitude_out(mag_o), .run_reverse_out(rev_o), .cmd_out(cmd),
      .cmd_valid_out(valid), .instruction_done_flag_out(done));
   crre_exec_model u_exec (.clk_in(clk_in), .rst_in(rst_in), .cmd_in(cmd), .cmd_valid_in(valid),
      .cmd_ack_out(ack));

   task report_and_stop;
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [34:0] got, input logic [34:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task step(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   task commit(input logic [15:0] w, input logic nv = 1'b0);
      trq = w;
      {nv_req, ram_req} = {nv, !nv};
      step(1);
      {nv_req, ram_req} = 2'h0;
      step(1);
   endtask
   // request goes up only once every slot word is in place
   task run_chain;
      step(1);
      exec_req = 1'b1;
      for (int k = 0; k < 300 && done !== 1'b1; k++) step(1);
      if (done !== 1'b1) begin
         miscompares++;
         report_and_stop;
      end
   endtask

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   initial begin
      {rst_in, ram_req, nv_req, trq_ctl, vec, sgn, rev_in, exec_req} = 8'h80;
      {meas, dev, trq, freq, src, meth} = '0;
      base = '0;
      chain = '0;
      step(5);
      rst_in = 1'b0;
      chk(meas_o, 35'h0);
      chk(done, 35'h0);
      meas = 16'h2710;
      dev = 16'hd8f0;
      step(2);
      chk(meas_o, 35'h2710);
      chk(dev_o, 35'hd8f0);
      meas = 16'h2711;
      dev = 16'hd8ef;
      step(2);
      chk({meas_o, dev_o}, 35'h2710d8f0);
      src = 3'h3;
      trq_ctl = 1'b1;
      vec = 1'b1;
      trq = 16'h0fa0;
      step(2);
      chk(ram_o, 35'h0);
      chk({is_cmd, is_lim}, 35'h2);
      commit(16'h0fa0);
      chk({ram_o, sec_o}, 35'h0fa00fa0);
      commit(16'h0fa1, 1'b1);
      chk(ram_o, 35'h0fa0);
      commit(16'h07d0, 1'b1);
      chk({ram_o, sec_o}, 35'h07d007d0);
      vec = 1'b0;
      commit(16'h0064);
      chk(ram_o, 35'h07d0);
      chk({is_cmd, is_lim}, 35'h0);
      {trq_ctl, src, meth} = {1'b0, 3'h5, 2'h1};
      commit(16'hec78);
      chk(ram_o, 35'h07d0);
      chk({is_cmd, is_lim}, 35'h0);
      meth = 2'h2;
      commit(16'hec78);
      chk({ram_o, sec_o}, 35'hec78ec78);
      chk({is_cmd, is_lim}, 35'h1);
      commit(16'hd8ef);
      chk(ram_o, 35'hec78);
      freq = 16'hff9c;
      step(2);
      chk({rev_o, mag_o}, 35'h0ff9c);
      {sgn, freq} = {1'b1, 16'hff9c};
      step(2);
      chk({rev_o, mag_o}, 35'h10064);
      {rev_in, freq} = {1'b1, 16'h8000};
      step(2);
      chk({rev_o, mag_o}, 35'h08000);
      base = '{16'h1234, 16'h5678};
      for (int i = 0; i < CHAIN_SLOTS; i++) chain[i] = '{16'h0a10 + 16'(i), 16'h0b00 + 16'(i)};
      chain[1] = '{DISABLE_CODE, 16'h0000};
      chain[3] = '{DISABLE_CODE, 16'h0000};
      run_chain;
      chk(35'(u_exec.log_q.size()), 35'h4);
      chk(u_exec.log_q[0], {base, 3'h0});
      for (int j = 0; j < 3; j++) chk(u_exec.log_q[j + 1], {chain[2 * j], 3'(2 * j + 1)});
      step(5);
      chk(done, 35'h1);
      chk(35'(u_exec.log_q.size()), 35'h4);
      exec_req = 1'b0;
      step(2);
      chk(done, 35'h0);
      base = '{DISABLE_CODE, 16'h0000};
      for (int i = 0; i < CHAIN_SLOTS; i++) chain[i] = '{DISABLE_CODE, 16'h0000};
      run_chain;
      chk(35'(u_exec.log_q.size()), 35'h5);
      chk(u_exec.log_q[4], {base, 3'h0});
      report_and_stop;
   end
endmodule
